//--- hdl/seq_step_consts.svh
// Register numbers, field positions, reset values and counts of the step bank
`ifndef SEQ_STEP_CONSTS_SVH
`define SEQ_STEP_CONSTS_SVH

// ****************************************
// Register numbers
// ****************************************
`define STEP_BASE 20'h53020
`define STEP_LAST 20'h5321F
`define SEG_SELECT_REG 20'h556E0
`define AVAIL_REG 20'h55800
`define CTRL_REG 20'h55801
`define STATUS_REG 20'h55802
`define IRQ_STATUS_REG 20'h55803
`define IRQ_CLEAR_REG 20'h55804
`define IRQ_ENABLE_REG 20'h55805
`define INTERVAL_REG 20'h55806
`define OFFSET_REG 20'h55807
`define LENGTH_REG 20'h55808

// ****************************************
// Field positions
// ****************************************
`define SEG_MSB 15
`define SEG_LSB 0
`define NEXT_MSB 31
`define NEXT_LSB 16
`define REPEAT_MSB 19
`define TRIG_FLAG_BIT 30
`define FINAL_FLAG_BIT 31
`define CTRL_START_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_ARM_BIT 2
`define IRQ_NOTIFY_BIT 0
`define IRQ_DONE_BIT 1
`define IRQ_SEQEND_BIT 2

// ****************************************
// Counts and reset values
// ****************************************
`define STEP_COUNT 32'h00000200
`define BYTES_PER_WORD 32'h00000004
`define SEG_SELECT_RST 16'h0000
`define IRQ_EN_RST 3'h0
`define WORD_RST 32'h00000000

`endif

//--- hdl/seq_step_pkg.sv
// Types shared by the step bank and its sequencer
package seq_step_pkg;

	typedef enum logic [1:0] {
		SQ_IDLE,
		SQ_FETCH,
		SQ_LOAD,
		SQ_PLAY
	} seq_phase_t;

	typedef struct packed {
		seq_phase_t phase;
		logic [8:0] idx;
		logic [63:0] entry;
		logic [19:0] loops;
		logic trig_seen;
		logic end_evt;
	} seq_rec_t;

	typedef struct packed {
		logic [15:0] seg_sel;
		logic [2:0] irq_st;
		logic [2:0] irq_en;
		logic [31:0] interval;
		logic [31:0] offset;
		logic [31:0] length;
		logic busy;
		logic [31:0] moved;
		logic [31:0] since;
		logic mem_we;
		logic [31:0] mem_addr;
		logic [31:0] mem_data;
		logic [63:0] rdata;
		logic [63:0] seq_entry;
		logic trig_s1;
		logic trig_s2;
		logic start_p;
		logic stop_p;
	} bank_rec_t;

endpackage

//--- hdl/seq_if.sv
// Link between the step bank and the replay sequencer
`timescale 1ns/1ns
interface seq_if;
	logic [8:0] step_idx;
	logic [63:0] entry;
	logic start;
	logic stop;
	logic trig;
	logic seg_done;
	logic active;
	logic end_evt;
	logic [15:0] segment;
	logic [8:0] cur_step;

	modport bank (
		input step_idx,
		input active,
		input end_evt,
		input segment,
		input cur_step,
		output entry,
		output start,
		output stop,
		output trig,
		output seg_done
	);

	modport seq (
		output step_idx,
		output active,
		output end_evt,
		output segment,
		output cur_step,
		input entry,
		input start,
		input stop,
		input trig,
		input seg_done
	);
endinterface

//--- hdl/seq_stepper.sv
// Replay sequencer walking the step memory
`timescale 1ns/1ns
`include "seq_step_consts.svh"
module seq_stepper import seq_step_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	seq_if.seq sq
);

	seq_rec_t s_r;
	seq_rec_t s_nxt;
	logic [19:0] target;
	logic [19:0] loops_inc;
	logic trig_now;

	// ****************************************
	// Step walk
	// ****************************************
	// Zero repeats is treated as one pass so a step can never stall
	assign target = (s_r.entry[32 +: 20] == 20'h00000) ? 20'h00001 :
		s_r.entry[32 +: 20];
	assign loops_inc = s_r.loops + 20'h00001;
	assign trig_now = s_r.trig_seen | sq.trig;

	always_comb begin
		s_nxt = s_r;
		s_nxt.end_evt = 1'b0;
		unique case (s_r.phase)
			SQ_IDLE: begin
				if (sq.start) begin
					s_nxt.idx = 9'h000;
					s_nxt.phase = SQ_FETCH;
				end
			end
			// Bank registers the entry at this edge
			SQ_FETCH: begin
				s_nxt.phase = SQ_LOAD;
			end
			// Copy taken on entry so runtime edits act next visit
			SQ_LOAD: begin
				s_nxt.entry = sq.entry;
				s_nxt.loops = 20'h00000;
				s_nxt.trig_seen = 1'b0;
				s_nxt.phase = SQ_PLAY;
			end
			SQ_PLAY: begin
				if (sq.trig) begin
					s_nxt.trig_seen = 1'b1;
				end
				if (sq.seg_done) begin
					s_nxt.loops = loops_inc;
					if (loops_inc >= target) begin
						s_nxt.loops = 20'h00000;
						if (s_r.entry[32 + `TRIG_FLAG_BIT] && !trig_now) begin
							s_nxt.phase = SQ_PLAY;
						end else if (s_r.entry[32 + `FINAL_FLAG_BIT]) begin
							s_nxt.phase = SQ_IDLE;
							s_nxt.end_evt = 1'b1;
						end else begin
							s_nxt.idx = s_r.entry[`NEXT_LSB +: 9];
							s_nxt.phase = SQ_FETCH;
						end
					end
				end
			end
		endcase
		if (sq.stop) begin
			s_nxt.phase = SQ_IDLE;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs to bank and replay datapath
	assign sq.step_idx = s_r.idx;
	assign sq.active = (s_r.phase == SQ_PLAY);
	assign sq.segment = s_r.entry[`SEG_MSB:`SEG_LSB];
	assign sq.end_evt = s_r.end_evt;
	assign sq.cur_step = s_r.idx;

endmodule

//--- hdl/seq_step_bank.sv
// Sequence step memory, transfer setup and register port of the generator
// Notes on behaviour
// - Event each time programmed byte count moves; zero means end only.
// - Transfer offset and length are relative to the selected segment.
// - Entry taken as one 64-bit access or two 32-bit halves.
// - Step n sits at base register number plus n.
// - Lower half bits 15..0 pick the replayed segment.
// - Lower half bits 31..16 hold the following step index.
// - Field masks lie within one half, valid for both access widths.
// - Upper half low 20 bits give segment repeat count.
// - Trigger flag: advance after loops only if trigger seen; held.
// - Upper half top bit marks last step; replay stops after it.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`include "seq_step_consts.svh"
module seq_step_bank import seq_step_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [19:0] reg_addr,
	input wire logic [63:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_wide,
	input wire logic reg_upper,
	output logic [63:0] reg_rdata,
	output logic irq,
	input wire logic din_valid,
	input wire logic [31:0] din_data,
	output logic din_ready,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic trigger_pin,
	input wire logic seg_done,
	output logic [15:0] play_segment,
	output logic play_active
);

	// ****************************************
	// Storage
	// ****************************************
	// Halves kept apart so a 32-bit write touches one only
	logic [31:0] step_lo [0:511];
	logic [31:0] step_hi [0:511];
	bank_rec_t s_r;
	bank_rec_t s_nxt;
	seq_if link ();

	logic in_steps;
	logic [19:0] rel;
	logic [8:0] widx;
	logic [63:0] host_entry;
	logic [31:0] moved_inc;
	logic [31:0] since_inc;
	logic [31:0] board_byte;
	logic [2:0] events;
	logic [2:0] clr;

	// ****************************************
	// Address decode
	// ****************************************
	// Step number straight from register number minus base
	assign in_steps = (reg_addr >= `STEP_BASE) &&
		(reg_addr <= `STEP_LAST);
	assign rel = reg_addr - `STEP_BASE;
	assign widx = rel[8:0];
	assign host_entry = {step_hi[widx], step_lo[widx]};
	assign moved_inc = s_r.moved + `BYTES_PER_WORD;
	assign since_inc = s_r.since + `BYTES_PER_WORD;
	// Offset counts from the selected segment, not memory start
	assign board_byte = s_r.offset + s_r.moved;

	// ****************************************
	// Step memory writes
	// ****************************************
	// Half select only matters for narrow accesses
	always_ff @(posedge mclk) begin
		if (reg_wr && in_steps) begin
			if (reg_wide || !reg_upper) begin
				step_lo[widx] <= reg_wdata[31:0];
			end
			if (reg_wide) begin
				step_hi[widx] <= reg_wdata[63:32];
			end else if (reg_upper) begin
				step_hi[widx] <= reg_wdata[31:0];
			end
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		events = 3'h0;
		clr = 3'h0;
		s_nxt.start_p = 1'b0;
		s_nxt.stop_p = 1'b0;
		s_nxt.mem_we = 1'b0;
		s_nxt.rdata = 64'h0000000000000000;

		// Trigger pin synchroniser, second stage is the only reader
		s_nxt.trig_s1 = trigger_pin;
		s_nxt.trig_s2 = s_r.trig_s1;

		// Read-before-write fetch for the sequencer
		s_nxt.seq_entry = {step_hi[link.step_idx], step_lo[link.step_idx]};

		// Host to board stream into the selected segment
		if (s_r.busy && din_valid) begin
			s_nxt.mem_we = 1'b1;
			s_nxt.mem_addr = {s_r.seg_sel, board_byte[17:2]};
			s_nxt.mem_data = din_data;
			s_nxt.moved = moved_inc;
			s_nxt.since = since_inc;
			if (s_r.interval != `WORD_RST && since_inc >= s_r.interval) begin
				events[`IRQ_NOTIFY_BIT] = 1'b1;
				s_nxt.since = `WORD_RST;
			end
			if (moved_inc >= s_r.length) begin
				s_nxt.busy = 1'b0;
				events[`IRQ_DONE_BIT] = 1'b1;
			end
		end
		events[`IRQ_SEQEND_BIT] = link.end_evt;

		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				`SEG_SELECT_REG: begin
					s_nxt.seg_sel = reg_wdata[15:0];
				end
				`CTRL_REG: begin
					s_nxt.start_p = reg_wdata[`CTRL_START_BIT];
					s_nxt.stop_p = reg_wdata[`CTRL_STOP_BIT];
					if (reg_wdata[`CTRL_ARM_BIT]) begin
						// Zero length arms nothing
						s_nxt.busy = (s_r.length != `WORD_RST);
						s_nxt.moved = `WORD_RST;
						s_nxt.since = `WORD_RST;
					end
				end
				`IRQ_CLEAR_REG: begin
					clr = reg_wdata[2:0];
				end
				`IRQ_ENABLE_REG: begin
					s_nxt.irq_en = reg_wdata[2:0];
				end
				`INTERVAL_REG: begin
					s_nxt.interval = reg_wdata[31:0];
				end
				`OFFSET_REG: begin
					s_nxt.offset = reg_wdata[31:0];
				end
				`LENGTH_REG: begin
					s_nxt.length = reg_wdata[31:0];
				end
				default: begin
				end
			endcase
		end

		// An event in the clearing cycle survives the clear
		s_nxt.irq_st = (s_r.irq_st & ~clr) | events;

		// Register reads, answered one cycle later
		if (reg_rd) begin
			if (in_steps) begin
				if (reg_wide) begin
					s_nxt.rdata = host_entry;
				end else if (reg_upper) begin
					s_nxt.rdata = {32'h00000000, host_entry[63:32]};
				end else begin
					s_nxt.rdata = {32'h00000000, host_entry[31:0]};
				end
			end else begin
				unique case (reg_addr)
					`SEG_SELECT_REG: begin
						s_nxt.rdata = {48'h000000000000, s_r.seg_sel};
					end
					`AVAIL_REG: begin
						s_nxt.rdata = {32'h00000000, `STEP_COUNT};
					end
					`STATUS_REG: begin
						s_nxt.rdata = {39'h0000000000, link.cur_step,
							14'h0000, s_r.busy, link.active};
					end
					`IRQ_STATUS_REG: begin
						s_nxt.rdata = {61'h0000000000000000, s_r.irq_st};
					end
					`IRQ_ENABLE_REG: begin
						s_nxt.rdata = {61'h0000000000000000, s_r.irq_en};
					end
					`INTERVAL_REG: begin
						s_nxt.rdata = {32'h00000000, s_r.interval};
					end
					`OFFSET_REG: begin
						s_nxt.rdata = {32'h00000000, s_r.offset};
					end
					`LENGTH_REG: begin
						s_nxt.rdata = {32'h00000000, s_r.length};
					end
					default: begin
						s_nxt.rdata = 64'h0000000000000000;
					end
				endcase
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_r <= '0;
			s_r.seg_sel <= `SEG_SELECT_RST;
			s_r.irq_en <= `IRQ_EN_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Sequencer and outputs
	// ****************************************
	assign link.entry = s_r.seq_entry;
	assign link.start = s_r.start_p;
	assign link.stop = s_r.stop_p;
	assign link.trig = s_r.trig_s2;
	assign link.seg_done = seg_done;

	seq_stepper u_stepper (
		.mclk(mclk),
		.reset(reset),
		.sq(link.seq)
	);

	// Ready comes straight from the busy register; a stalled source holds its word
	assign din_ready = s_r.busy;
	assign mem_we = s_r.mem_we;
	assign mem_addr = s_r.mem_addr;
	assign mem_wdata = s_r.mem_data;
	assign reg_rdata = s_r.rdata;
	assign irq = |(s_r.irq_st & s_r.irq_en);
	assign play_segment = link.segment;
	assign play_active = link.active;

endmodule

//--- bench/bank_checker.sv
// Port assertions for the step bank
`timescale 1ns/1ns
`include "seq_step_consts.svh"
module bank_checker (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [19:0] reg_addr,
	input wire logic [63:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [63:0] reg_rdata,
	input wire logic irq,
	input wire logic din_ready,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic seg_done,
	input wire logic [15:0] play_segment,
	input wire logic play_active
);
	// ****
	// Shadow of host settings
	// ****
	logic [15:0] sel_r;
	logic [2:0] en_r;
	logic [31:0] len_r, cnt_r;
	logic ctl_w;
	assign ctl_w = reg_wr && reg_addr == `CTRL_REG;
	// Words counted from each arm, to bound a transfer
	always_ff @(posedge mclk) begin
		if (reset) begin
			sel_r <= 16'h0000;
			en_r <= 3'h0;
			len_r <= 32'h0;
			cnt_r <= 32'h0;
		end else begin
			if (reg_wr && reg_addr == `SEG_SELECT_REG)
				sel_r <= reg_wdata[15:0];
			if (reg_wr && reg_addr == `IRQ_ENABLE_REG)
				en_r <= reg_wdata[2:0];
			if (reg_wr && reg_addr == `LENGTH_REG)
				len_r <= reg_wdata[31:0];
			if (ctl_w && reg_wdata[2])
				cnt_r <= 32'h0;
			else if (mem_we)
				cnt_r <= cnt_r + 32'h1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 64'h0)
		else $error("read data outside slot");
	count_read_a: assert property (reg_rd && reg_addr == `AVAIL_REG
		|=> reg_rdata == 64'h200) else $error("step count wrong");
	seg_addr_a: assert property (mem_we |-> mem_addr[31:16] == sel_r)
		else $error("word outside segment");
	word_limit_a: assert property (mem_we |-> cnt_r * 32'h4 < len_r)
		else $error("word past length");
	ready_arm_a: assert property ($rose(din_ready)
		|-> $past(ctl_w && reg_wdata[2])) else $error("ready without arm");
	irq_off_a: assert property (en_r == 3'h0 && $past(en_r) == 3'h0
		|-> !irq) else $error("masked irq high");
	start_play_a: assert property (ctl_w && reg_wdata[0]
		|-> ##[1:6] play_active) else $error("start not played");
	seg_stable_a: assert property (play_active && !seg_done ##1
		play_active |-> $stable(play_segment)) else $error("segment moved");
	cover property (mem_we ##1 !din_ready);
	cover property ($fell(play_active));
	cover property (irq);
endmodule
bind seq_step_bank bank_checker chk_i (.mclk(mclk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
	.din_ready(din_ready), .mem_we(mem_we), .mem_addr(mem_addr),
	.seg_done(seg_done), .play_segment(play_segment),
	.play_active(play_active));

//--- bench/host_feeder.sv
// Host-side model pushing words into the board
`timescale 1ns/1ns
module host_feeder (
	input wire logic mclk,
	input wire logic reset,
	input wire logic go,
	input wire logic [31:0] count,
	input wire logic [31:0] base,
	output logic din_valid,
	output logic [31:0] din_data,
	input wire logic din_ready
);
	logic [31:0] left_r;
	// Each word held until taken; host to board only
	always @(posedge mclk) begin
		if (reset) begin
			left_r <= 32'h0;
			din_valid <= 1'h0;
			din_data <= 32'h0;
		end else if (go) begin
			left_r <= count;
			din_valid <= count != 32'h0;
			din_data <= base;
		end else if (din_valid && din_ready) begin
			left_r <= left_r - 32'h1;
			din_valid <= left_r > 32'h1;
			// Released data scrambled so a stale word never looks valid
			din_data <= left_r > 32'h1 ? din_data + 32'h1 : ~din_data;
		end
	end
endmodule

//--- bench/testbench.sv
// Self-checking bench for the step bank
`timescale 1ns/1ns
`include "seq_step_consts.svh"
module testbench;
	logic mclk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic reg_wide = 1'h0, reg_upper = 1'h0, go = 1'h0;
	logic trigger_pin = 1'h0, seg_done = 1'h0;
	logic [19:0] reg_addr = 20'h0, a;
	logic [63:0] reg_wdata = 64'h0, reg_rdata, d;
	logic irq, din_valid, din_ready, mem_we, play_active;
	logic [31:0] din_data, mem_addr, mem_wdata, base, off, k;
	logic [31:0] rng = 32'h17;
	logic [15:0] play_segment, sel, s0, s1;
	int mismatches = 0, cmp_count = 0;
	seq_step_bank dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wide(reg_wide), .reg_upper(reg_upper), .reg_rdata(reg_rdata),
		.irq(irq), .din_valid(din_valid), .din_data(din_data),
		.din_ready(din_ready), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .trigger_pin(trigger_pin),
		.seg_done(seg_done), .play_segment(play_segment),
		.play_active(play_active));
	host_feeder feed (.mclk(mclk), .reset(reset), .go(go),
		.count(32'h5), .base(base), .din_valid(din_valid),
		.din_data(din_data), .din_ready(din_ready));
	// ****
	// Helpers
	// ****
	always #2 mclk = ~mclk;
	function logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function logic [31:0] exp_addr(input logic [31:0] b);
		return {sel, b[17:2]};
	endfunction
	task final_report();
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input logic [63:0] e, g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// Bus cycles; a spare edge keeps strobes from being set twice at once
	task wr(input logic [19:0] ad, input logic [63:0] wd, input logic w, u);
		reg_addr <= ad;
		reg_wdata <= wd;
		reg_wide <= w;
		reg_upper <= u;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
		@(posedge mclk);
	endtask
	task rd(input logic [19:0] ad, input logic w, u, input logic [63:0] e);
		reg_addr <= ad;
		reg_wide <= w;
		reg_upper <= u;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1 chk("reg_rdata", e, reg_rdata);
		@(posedge mclk);
	endtask
	task wait_for(input logic v);
		for (int n = 0; n < 40 && play_active !== v; n++)
			@(posedge mclk);
		#1 chk("play_active", 64'(v), 64'(play_active));
		@(posedge mclk);
	endtask
	task pulse_done();
		seg_done <= 1'h1;
		@(posedge mclk);
		seg_done <= 1'h0;
		repeat (3) @(posedge mclk);
	endtask
	// Every stored word lands at its segment-relative place
	always @(posedge mclk) begin
		if (mem_we === 1'h1) begin
			chk("mem_addr", 64'(exp_addr(off + k * 4)), 64'(mem_addr));
			chk("mem_wdata", 64'(base + k), 64'(mem_wdata));
			k = k + 32'h1;
		end
	end
	// Watchdog, far beyond the run length
	initial begin
		repeat (5000) @(posedge mclk);
		mismatches++;
		final_report();
	end
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (12) @(posedge mclk);
		reset <= 1'h0;
		@(posedge mclk);
		rd(`AVAIL_REG, 1'h1, 1'h0, 64'h200);
		rd(20'h0, 1'h1, 1'h0, 64'h0);
		// Whole and split step accesses, last step included
		for (int i = 0; i < 4; i++) begin
			a = i == 3 ? `STEP_LAST : `STEP_BASE + 20'(rnd() & 32'h1FF);
			d = {rnd(), rnd()};
			wr(a, d, 1'h1, 1'h0);
			rd(a, 1'h1, 1'h0, d);
			wr(a, 64'(d[63:32]), 1'h0, 1'h0);
			wr(a, 64'(d[31:0]), 1'h0, 1'h1);
			rd(a, 1'h0, 1'h0, 64'(d[63:32]));
			rd(a, 1'h1, 1'h0, {d[31:0], d[63:32]});
		end
		// Transfers with a byte interval, then with none
		for (int r = 0; r < 2; r++) begin
			sel = 16'(rnd());
			off = rnd() & 32'h0000FFFC;
			base = rnd();
			k = 32'h0;
			wr(`SEG_SELECT_REG, 64'(sel), 1'h0, 1'h0);
			wr(`OFFSET_REG, 64'(off), 1'h0, 1'h0);
			wr(`INTERVAL_REG, r ? 64'h0 : 64'h8, 1'h0, 1'h0);
			wr(`LENGTH_REG, 64'h14, 1'h0, 1'h0);
			wr(`IRQ_ENABLE_REG, 64'h3, 1'h0, 1'h0);
			wr(`CTRL_REG, 64'h4, 1'h0, 1'h0);
			go <= 1'h1;
			@(posedge mclk);
			go <= 1'h0;
			for (int n = 0; n < 40 && din_ready !== 1'h0; n++)
				@(posedge mclk);
			repeat (2) @(posedge mclk);
			chk("words", 64'h5, 64'(k));
			rd(`IRQ_STATUS_REG, 1'h0, 1'h0, r ? 64'h2 : 64'h3);
			chk("irq", 64'h1, 64'(irq));
			wr(`IRQ_ENABLE_REG, 64'h0, 1'h0, 1'h0);
			chk("irq", 64'h0, 64'(irq));
			wr(`IRQ_CLEAR_REG, 64'h7, 1'h0, 1'h0);
			rd(`IRQ_STATUS_REG, 1'h0, 1'h0, 64'h0);
		end
		// Two steps: repeat, successor, trigger hold, last step
		s0 = 16'(rnd());
		s1 = 16'(rnd());
		wr(`STEP_BASE, {32'h2, 16'h1, s0}, 1'h1, 1'h0);
		wr(`STEP_BASE + 20'h1, {32'hC0000001, 16'h0, s1}, 1'h1, 1'h0);
		wr(`IRQ_ENABLE_REG, 64'h4, 1'h0, 1'h0);
		wr(`CTRL_REG, 64'h1, 1'h0, 1'h0);
		wait_for(1'h1);
		chk("segment", 64'(s0), 64'(play_segment));
		// Status while step 0 plays: active set, transfer idle, index zero
		rd(`STATUS_REG, 1'h0, 1'h0, 64'h1);
		pulse_done();
		wait_for(1'h1);
		chk("segment", 64'(s0), 64'(play_segment));
		pulse_done();
		wait_for(1'h1);
		chk("segment", 64'(s1), 64'(play_segment));
		pulse_done();
		wait_for(1'h1);
		chk("segment", 64'(s1), 64'(play_segment));
		trigger_pin <= 1'h1;
		@(posedge mclk);
		trigger_pin <= 1'h0;
		repeat (4) @(posedge mclk);
		pulse_done();
		wait_for(1'h0);
		chk("irq", 64'h1, 64'(irq));
		// Restart, then a stop pulse must drop replay within 40 cycles
		wr(`CTRL_REG, 64'h1, 1'h0, 1'h0);
		wait_for(1'h1);
		chk("segment", 64'(s0), 64'(play_segment));
		wr(`CTRL_REG, 64'h2, 1'h0, 1'h0);
		wait_for(1'h0);
		final_report();
	end
endmodule
